// ===== hw/rpc_pkg.sv
package rpc_pkg;
  // register offsets on the register port
  localparam logic [7:0] RPC_ADDR_MAILBOX = 8'h79;
  localparam logic [7:0] RPC_ADDR_ERR_FLAGS = 8'h7A;
  localparam logic [7:0] RPC_ADDR_ERR_COUNT = 8'h7B;
  localparam logic [7:0] RPC_ADDR_VIDEO_CFG = 8'h7C;
  localparam logic [7:0] RPC_ADDR_PASS_CTL = 8'h7D;
  // reset values
  localparam logic [7:0] RPC_RST_MAILBOX = 8'h01;
  localparam logic [7:0] RPC_RST_ERR_FLAGS = 8'h00;
  localparam logic [7:0] RPC_RST_ERR_COUNT = 8'h00;
  localparam logic [7:0] RPC_RST_VIDEO_CFG = 8'h20;
  localparam logic [7:0] RPC_RST_PASS_CTL = 8'h00;
  // packet error flag bits
  localparam int RPC_BIT_LEN = 3;
  localparam int RPC_BIT_CKSUM = 2;
  localparam int RPC_BIT_ECC2 = 1;
  localparam int RPC_BIT_ECC1 = 0;
  // video handling fields
  localparam int RPC_PACK_HI = 7;
  localparam int RPC_PACK_LO = 6;
  localparam int RPC_BIT_PAR = 5;
  localparam int RPC_BIT_LINE = 4;
  localparam int RPC_BIT_FRAME = 3;
  localparam int RPC_BIT_AUTO = 2;
  localparam int RPC_BIT_LV_INV = 1;
  localparam int RPC_BIT_FV_INV = 0;
  // threshold field of pass qualify control
  localparam int RPC_THR_HI = 1;
  localparam int RPC_THR_LO = 0;
  localparam logic [7:0] RPC_CNT_MAX = 8'hFF;
  localparam logic [7:0] RPC_ZERO = 8'h00;
  localparam logic [1:0] RPC_THR_ZERO = 2'h0;

  // packing selections
  typedef enum logic [1:0] {
    RPC_PACK_NORMAL = 2'b00,
    RPC_PACK_RSVD = 2'b01,
    RPC_PACK_UPPER = 2'b10,
    RPC_PACK_LOWER = 2'b11
  } rpc_pack_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpc_req_t;

  // one packet status report from the receiver
  typedef struct packed {
    logic done;
    logic len_err;
    logic payload_checksum_flag;
    logic header_multibit_flag;
    logic header_singlebit_flag;
  } rpc_pkt_t;

  // one video word entering or leaving the port
  typedef struct packed {
    logic line_valid;
    logic frame_valid;
    logic [9:0] pixel;
  } rpc_pix_t;
endpackage

// ===== hw/rpc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;
  logic [AW:0] next_fill;

  assign next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= next_fill;
      // ready from a flop so the port output is registered
      in_ready <= (next_fill != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// ===== hw/rpc_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - mailbox byte read/write, resets to one
// - length mismatch sets flag bit three
// - payload checksum failure sets flag bit two
// - multibit header error sets bit one
// - singlebit header error corrected, sets bit zero
// - flags sticky, cleared by read, upper zero
// - errored packet count, restarts on read
// - packing select: normal, reserved, upper, lower
// - eight-bit packing of raw ten pixels
// - parity error truncates frame when enabled
// - line size change truncates when enabled
// - line count change truncates when enabled
// - after line count truncation wait threshold frames
// - threshold zero passes at lock, else frames
// - auto polarity inferred from incoming stream
// - auto polarity drops first frame only if frame valid polarity changes
// - manual polarity from two control bits
// - line valid invert bit means active low
// - frame valid invert bit means active low
module rpc_port_regs #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port, reached once the host has chosen this port
  input wire rpc_pkg::rpc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // receiver status
  input wire rpc_pkg::rpc_pkt_t pkt,
  input wire logic rx_lock,
  input wire logic parity_err,
  input wire logic raw10_mode,
  // incoming video
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire rpc_pkg::rpc_pix_t pix_in,
  // outgoing video
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output rpc_pkg::rpc_pix_t pix_out,
  output logic pass
);
  import rpc_pkg::*;

  logic [7:0] mailbox;
  logic [3:0] err_flags;
  logic [7:0] err_count;
  logic [7:0] video_cfg;
  logic [7:0] pass_ctl;
  logic rd_flags;
  logic rd_count;
  logic [3:0] new_err;
  logic pkt_bad;
  logic [3:0] next_flags;
  rpc_pack_t pack_sel;
  logic lv_act;
  logic fv_act;
  logic lv_pol;
  logic fv_pol;
  logic fv_prev;
  logic frame_start;
  logic frame_end;
  logic [15:0] line_len;
  logic [15:0] last_line_len;
  logic [15:0] line_cnt;
  logic [15:0] last_line_cnt;
  logic line_seen;
  logic frame_seen;
  logic line_chg;
  logic frame_chg;
  logic truncate;
  logic [1:0] good_frames;
  logic auto_done;
  logic frame_drop;
  rpc_pix_t packed_pix;
  logic fifo_in_ready;
  logic fifo_out_valid;
  rpc_pix_t fifo_out;
  logic lv_prev;
  logic take;
  logic start_drop;
  logic keep_word;

  typedef enum logic [1:0] {
    RPC_ST_WAIT,
    RPC_ST_PASS,
    RPC_ST_TRUNC
  } rpc_state_t;
  rpc_state_t state;

  assign pack_sel = rpc_pack_t'(video_cfg[RPC_PACK_HI:RPC_PACK_LO]);
  assign rd_flags = req.rd && (req.addr == RPC_ADDR_ERR_FLAGS);
  assign rd_count = req.rd && (req.addr == RPC_ADDR_ERR_COUNT);

  // error events from the current packet report
  assign new_err[RPC_BIT_LEN] = pkt.done && pkt.len_err;
  assign new_err[RPC_BIT_CKSUM] = pkt.done && pkt.payload_checksum_flag;
  assign new_err[RPC_BIT_ECC2] = pkt.done && pkt.header_multibit_flag;
  assign new_err[RPC_BIT_ECC1] = pkt.done && pkt.header_singlebit_flag;
  assign pkt_bad = |new_err;
  // a set in the read cycle survives the clear
  assign next_flags = (rd_flags ? 4'h0 : err_flags) | new_err;

  // mailbox and configuration writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox <= RPC_RST_MAILBOX;
      video_cfg <= RPC_RST_VIDEO_CFG;
      pass_ctl <= RPC_RST_PASS_CTL;
    end else if (req.wr) begin
      if (req.addr == RPC_ADDR_MAILBOX) begin
        mailbox <= req.wdata;
      end else if (req.addr == RPC_ADDR_VIDEO_CFG) begin
        video_cfg <= req.wdata;
      end else if (req.addr == RPC_ADDR_PASS_CTL) begin
        pass_ctl <= req.wdata;
      end
    end
  end

  // sticky flags, cleared by host read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flags <= RPC_RST_ERR_FLAGS[3:0];
    end else begin
      err_flags <= next_flags;
    end
  end

  // errored packet tally, restart on read, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_count <= RPC_RST_ERR_COUNT;
    end else if (rd_count) begin
      err_count <= pkt_bad ? 8'h01 : RPC_ZERO;
    end else if (pkt_bad && err_count != RPC_CNT_MAX) begin
      err_count <= err_count + 8'h01;
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= RPC_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (!req.rd) begin
        rdata <= rdata;
      end else if (req.addr == RPC_ADDR_MAILBOX) begin
        rdata <= mailbox;
      end else if (req.addr == RPC_ADDR_ERR_FLAGS) begin
        rdata <= {4'h0, err_flags};
      end else if (req.addr == RPC_ADDR_ERR_COUNT) begin
        rdata <= err_count;
      end else if (req.addr == RPC_ADDR_VIDEO_CFG) begin
        rdata <= video_cfg;
      end else if (req.addr == RPC_ADDR_PASS_CTL) begin
        rdata <= pass_ctl;
      end else begin
        rdata <= RPC_ZERO;
      end
    end
  end

  // effective polarity: learned or programmed
  assign lv_act = pix_in.line_valid ^ lv_pol;
  assign fv_act = pix_in.frame_valid ^ fv_pol;

  // polarity tracking; idle level between frames is the inactive one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_pol <= 1'b0;
      fv_pol <= 1'b0;
      auto_done <= 1'b0;
    end else if (!video_cfg[RPC_BIT_AUTO]) begin
      lv_pol <= video_cfg[RPC_BIT_LV_INV];
      fv_pol <= video_cfg[RPC_BIT_FV_INV];
      auto_done <= 1'b0;
    end else if (pix_in_valid && pix_in_ready && !auto_done) begin
      // first word seen is taken as idle level
      lv_pol <= pix_in.line_valid;
      fv_pol <= pix_in.frame_valid;
      auto_done <= 1'b1;
    end
  end

  // frame edges on the normalised frame valid
  assign frame_start = fv_act && !fv_prev;
  assign frame_end = !fv_act && fv_prev;

  // line and frame size measurement
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fv_prev <= 1'b0;
      lv_prev <= 1'b0;
      line_len <= '0;
      last_line_len <= '0;
      line_cnt <= '0;
      last_line_cnt <= '0;
      line_seen <= 1'b0;
      frame_seen <= 1'b0;
    end else if (pix_in_valid && pix_in_ready) begin
      fv_prev <= fv_act;
      lv_prev <= lv_act;
      if (lv_act) begin
        line_len <= line_len + 16'h0001;
      end else if (lv_prev) begin
        last_line_len <= line_len;
        line_len <= '0;
        line_seen <= 1'b1;
        line_cnt <= line_cnt + 16'h0001;
      end
      if (frame_end) begin
        last_line_cnt <= line_cnt;
        line_cnt <= '0;
        frame_seen <= 1'b1;
        line_seen <= 1'b0;
      end
    end
  end

  // size changes, judged on accepted words only
  assign line_chg = take && lv_prev && !lv_act && line_seen
    && (line_len != last_line_len);
  assign frame_chg = take && frame_end && frame_seen
    && (line_cnt != last_line_cnt);

  // one accepted input word
  assign take = pix_in_valid && pix_in_ready;
  // drop decision of a new frame also covers its own first word
  assign start_drop = (state != RPC_ST_PASS)
    || (video_cfg[RPC_BIT_AUTO] && !auto_done);
  assign keep_word = frame_start ? !start_drop
    : (!frame_drop && !truncate);

  // frame truncation and pass qualification
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RPC_ST_WAIT;
      good_frames <= RPC_THR_ZERO;
      truncate <= 1'b0;
      frame_drop <= 1'b1;
    end else begin
      if (pix_in_valid && pix_in_ready && frame_start) begin
        truncate <= 1'b0;
        // auto mode drops the learning frame
        frame_drop <= start_drop;
      end
      // truncation sources inside a frame
      if (parity_err && video_cfg[RPC_BIT_PAR]) begin
        truncate <= 1'b1;
      end
      if (line_chg && video_cfg[RPC_BIT_LINE]) begin
        truncate <= 1'b1;
      end
      // pass qualification after lock, loss or truncation
      case (state)
        RPC_ST_WAIT: begin
          if (!rx_lock) begin
            good_frames <= RPC_THR_ZERO;
          end else if (pass_ctl[RPC_THR_HI:RPC_THR_LO] == RPC_THR_ZERO) begin
            state <= RPC_ST_PASS;
          end else if (take && frame_end) begin
            if (good_frames + 2'h1 == pass_ctl[RPC_THR_HI:RPC_THR_LO]) begin
              state <= RPC_ST_PASS;
            end
            good_frames <= good_frames + 2'h1;
          end
        end
        RPC_ST_PASS: begin
          if (!rx_lock) begin
            state <= RPC_ST_WAIT;
          end else if (frame_chg && video_cfg[RPC_BIT_FRAME]) begin
            state <= RPC_ST_TRUNC;
            truncate <= 1'b1;
          end
        end
        RPC_ST_TRUNC: begin
          good_frames <= RPC_THR_ZERO;
          state <= RPC_ST_WAIT;
        end
        default: state <= RPC_ST_WAIT;
      endcase
    end
  end

  // pixel repacking for eight-bit modes
  always_comb begin
    packed_pix = pix_in;
    if (raw10_mode && pack_sel == RPC_PACK_UPPER) begin
      packed_pix.pixel = {2'b00, pix_in.pixel[9:2]};
    end else if (raw10_mode && pack_sel == RPC_PACK_LOWER) begin
      packed_pix.pixel = {2'b00, pix_in.pixel[7:0]};
    end
    // valids leave normalised active high
    packed_pix.line_valid = lv_act;
    packed_pix.frame_valid = fv_act;
  end

  // dropped words are accepted but not stored
  assign pix_in_ready = fifo_in_ready;

  // elastic store toward the sink
  rpc_fifo #(
    .WIDTH($bits(rpc_pix_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(pix_in_valid && keep_word),
    .in_ready(fifo_in_ready),
    .in_data(packed_pix),
    .out_valid(fifo_out_valid),
    .out_ready(pix_out_ready || !pix_out_valid),
    .out_data(fifo_out)
  );

  // registered output stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out_valid <= 1'b0;
      pix_out <= '0;
      pass <= 1'b0;
    end else begin
      pass <= (state == RPC_ST_PASS);
      if (pix_out_ready || !pix_out_valid) begin
        pix_out_valid <= fifo_out_valid;
        pix_out <= fifo_out;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/rpc_port_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_port_regs_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire rpc_pkg::rpc_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // packets and video
  input wire rpc_pkg::rpc_pkt_t pkt,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready
);
  import rpc_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // reads of flags and tally
  logic rd_f;
  logic rd_c;
  assign rd_f = req.rd && req.addr == RPC_ADDR_ERR_FLAGS;
  assign rd_c = req.rd && req.addr == RPC_ADDR_ERR_COUNT;
  // mailbox keeps the written byte
  a_mailbox_read_back:
  assert property ((req.wr && req.addr == RPC_ADDR_MAILBOX) ##1 !req.wr
    ##1 (req.rd && req.addr == RPC_ADDR_MAILBOX) |=> rdata == $past(req.wdata, 3))
    else $error("mailbox read-back wrong");
  a_flags_upper_zero:
  assert property (rd_f |=> rdata[7:4] == 4'h0) else $error("flag upper bits set");
  a_length_flag_set:
  assert property ((pkt.done && pkt.len_err) ##1 !rd_f ##1 rd_f |=> rdata[RPC_BIT_LEN])
    else $error("length flag missing");
  a_cksum_flag_set:
  assert property ((pkt.done && pkt.payload_checksum_flag) ##1 !rd_f ##1 rd_f |=> rdata[RPC_BIT_CKSUM])
    else $error("checksum flag missing");
  a_multi_flag_set:
  assert property ((pkt.done && pkt.header_multibit_flag) ##1 !rd_f ##1 rd_f |=> rdata[RPC_BIT_ECC2])
    else $error("multibit flag missing");
  a_single_flag_set:
  assert property ((pkt.done && pkt.header_singlebit_flag) ##1 !rd_f ##1 rd_f |=> rdata[RPC_BIT_ECC1])
    else $error("singlebit flag missing");
  a_flags_read_clear:
  assert property ((rd_f && !pkt.done) ##1 !pkt.done ##1 (rd_f && !pkt.done) |=> rdata == 8'h00)
    else $error("flags not cleared");
  a_tally_read_clear:
  assert property ((rd_c && !pkt.done) ##1 !pkt.done ##1 (rd_c && !pkt.done) |=> rdata == 8'h00)
    else $error("tally not cleared");
  // main scenarios
  c_flag_read: cover property (rd_f ##1 rvalid);
  c_multi_err: cover property (pkt.done && pkt.header_multibit_flag);
  c_video_out: cover property (pix_out_valid && pix_out_ready);
endmodule
bind rpc_port_regs rpc_port_regs_sva chk_u (.ref_clk, .rst_n, .req, .rdata, .rvalid, .pkt,
  .pix_out_valid, .pix_out_ready);
`default_nettype wire

// ===== bench/rpc_cam_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_cam_model (
  // clock
  input wire logic ref_clk,
  // video toward the port
  input wire logic pix_in_ready,
  output logic pix_in_valid,
  output rpc_pkg::rpc_pix_t pix_in
);
  import rpc_pkg::*;
  // nothing offered at start
  initial begin
    pix_in_valid = 1'b0;
    pix_in = '0;
  end
  // one word held until taken
  task automatic word(input logic lv, input logic fv, input logic [9:0] px);
    pix_in_valid <= 1'b1;
    pix_in <= '{line_valid: lv, frame_valid: fv, pixel: px};
    do @(posedge ref_clk); while (!pix_in_ready);
    #1;
  endtask
  // nl lines of four pixels, the second len1 long; inv bits make valids active low
  task automatic frame(input logic [9:0] base, input logic [1:0] inv, input int len1,
    input int nl);
    word(inv[1], inv[0], 10'h000);
    for (int l = 0; l < nl; l++) begin
      for (int p = 0; p < ((l == 1) ? len1 : 4); p++)
        word(~inv[1], ~inv[0], base + 10'(l * 4 + p));
      word(inv[1], ~inv[0], 10'h000);
    end
    word(inv[1], inv[0], 10'h000);
    pix_in_valid <= 1'b0;
    pix_in.pixel <= ~pix_in.pixel; // no stale pixel once released
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== bench/test_rx_port_packet_check_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_port_packet_check_config;
  import rpc_pkg::*;
  logic ref_clk;
  logic rst_n;
  rpc_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  rpc_pkt_t pkt;
  logic rx_lock;
  logic parity_err;
  logic pix_in_valid;
  logic pix_in_ready;
  rpc_pix_t pix_in;
  logic pix_out_valid;
  logic pix_out_ready;
  rpc_pix_t pix_out;
  logic pass;
  int mismatches;
  int cmp_count;
  int acc = 0;
  int n;
  logic [9:0] got[$];
  logic [7:0] d;
  logic [3:0] e;
  logic [3:0] ef;
  logic raw10;
  logic [9:0] pbase;
  int seen_px;
  int cut;
  int lines;

  rpc_port_regs #(.FIFO_DEPTH(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .pkt(pkt), .rx_lock(rx_lock), .parity_err(parity_err),
    .raw10_mode(raw10), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
    .pix_in(pix_in), .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
    .pix_out(pix_out), .pass(pass));
  rpc_cam_model cam_u (.ref_clk(ref_clk), .pix_in_ready(pix_in_ready),
    .pix_in_valid(pix_in_valid), .pix_in(pix_in));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // taken input words and delivered pixels
  always @(posedge ref_clk) begin
    if (pix_in_valid && pix_in_ready) acc++;
    if (pix_out_valid && pix_out_ready && pix_out.line_valid && pix_out.frame_valid)
      got.push_back(pix_out.pixel);
  end
  // sink stalls at random
  initial begin
    pix_out_ready = 1'b1;
    forever begin
      @(posedge ref_clk);
      #1 pix_out_ready = ($urandom_range(3) != 0);
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end

  function automatic logic [7:0] tally(input int cnt);
    return (cnt > 255) ? 8'hff : 8'(cnt);
  endfunction
  // raw ten pixel as the eight-bit packing select should hand it on
  function automatic logic [9:0] pack_exp(input logic [7:0] cfg, input logic [9:0] px);
    if (raw10 && cfg[RPC_PACK_HI:RPC_PACK_LO] == RPC_PACK_UPPER) return {2'b00, px[9:2]};
    if (raw10 && cfg[RPC_PACK_HI:RPC_PACK_LO] == RPC_PACK_LOWER) return {2'b00, px[7:0]};
    return px;
  endfunction
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    req <= '{wr: wr, rd: ~wr, addr: a, wdata: wd}; // host has picked this port
    @(posedge ref_clk);
    #1 req <= '0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic pk(input logic [3:0] err);
    pkt <= {1'b1, err};
    @(posedge ref_clk);
    #1 pkt <= '0;
    @(posedge ref_clk);
    #1;
  endtask
  // frames through the port, parity pulse after np taken words, ff first frame out
  task automatic vid(input logic [7:0] cfg, input logic [1:0] inv, input int nf, input int np,
    input int ff);
    int acc0;
    int got0;
    acc0 = acc;
    got0 = got.size();
    bus(1'b1, RPC_ADDR_VIDEO_CFG, cfg);
    fork
      for (int f = 0; f < nf; f++) cam_u.frame(pbase + 10'(f * 16), inv, cut, lines);
      if (np > 0) begin
        wait (acc >= acc0 + np);
        #1 parity_err <= 1'b1;
        @(posedge ref_clk);
        #1 parity_err <= 1'b0;
      end
    join
    repeat (40) @(posedge ref_clk);
    #1 seen_px = got.size() - got0;
    if (seen_px > 0) chk("first pixel", pack_exp(cfg, pbase + 10'(ff * 16)), got[got0]);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    pkt = '0;
    rx_lock = 1'b0;
    parity_err = 1'b0;
    raw10 = 1'b0;
    cut = 4;
    lines = 3;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(36));
    pbase = 10'($urandom);
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rc(RPC_ADDR_MAILBOX, 8'h01);
    rc(RPC_ADDR_ERR_FLAGS, 8'h00);
    rc(RPC_ADDR_ERR_COUNT, 8'h00);
    rc(RPC_ADDR_VIDEO_CFG, 8'h20);
    bus(1'b1, 8'h80, 8'hff);
    rc(8'h80, 8'h00);
    // mailbox and packing select read back
    repeat (3) begin
      d = 8'($urandom);
      bus(1'b1, RPC_ADDR_MAILBOX, d);
      rc(RPC_ADDR_MAILBOX, d);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, RPC_ADDR_VIDEO_CFG, 8'(k << 6));
      rc(RPC_ADDR_VIDEO_CFG, 8'(k << 6));
    end
    // each flag alone, sticky then cleared
    for (int b = 0; b < 4; b++) begin
      pk(4'(1 << b));
      rc(RPC_ADDR_ERR_FLAGS, 8'(1 << b));
      rc(RPC_ADDR_ERR_FLAGS, 8'h00);
    end
    rc(RPC_ADDR_ERR_COUNT, tally(4));
    rc(RPC_ADDR_ERR_COUNT, 8'h00);
    // random reports, some clean
    ef = '0;
    n = 0;
    repeat (20) begin
      e = 4'($urandom);
      pk(e);
      ef = ef | e;
      n = n + int'(e != 4'h0);
    end
    rc(RPC_ADDR_ERR_FLAGS, {4'h0, ef});
    rc(RPC_ADDR_ERR_COUNT, tally(n));
    repeat (260) pk(4'h8);
    rc(RPC_ADDR_ERR_COUNT, tally(260));
    // pass follows lock at threshold zero
    bus(1'b1, RPC_ADDR_PASS_CTL, 8'h00);
    chk("pass", 0, pass);
    rx_lock = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 chk("pass", 1, pass);
    // manual polarity, all four settings
    for (int k = 0; k < 4; k++) begin
      vid(8'(k), 2'(k), 1, 0, 0);
      chk("pixels", 12, 10'(seen_px));
    end
    vid(8'h20, 2'b00, 1, 4, 0);
    chk("truncated", 1, 10'(seen_px < 12));
    vid(8'h00, 2'b00, 1, 4, 0);
    chk("pixels", 12, 10'(seen_px));
    vid(8'h04, 2'b11, 2, 0, 1);
    chk("pixels", 12, 10'(seen_px));
    // raw ten packing, upper then lower eight bits
    raw10 = 1'b1;
    vid(8'h80, 2'b00, 1, 0, 0);
    chk("pixels", 12, 10'(seen_px));
    vid(8'hc0, 2'b00, 1, 0, 0);
    chk("pixels", 12, 10'(seen_px));
    raw10 = 1'b0;
    // short second line, tolerated then truncated
    cut = 2;
    vid(8'h00, 2'b00, 1, 0, 0);
    chk("pixels", 10, 10'(seen_px));
    vid(8'h10, 2'b00, 1, 0, 0);
    chk("pixels", 6, 10'(seen_px));
    cut = 4;
    // line count change withholds frames until two good frames
    bus(1'b1, RPC_ADDR_PASS_CTL, 8'h02);
    lines = 2;
    vid(8'h08, 2'b00, 3, 0, 0);
    chk("pixels", 8, 10'(seen_px));
    chk("pass", 1, pass);
    vid(8'h08, 2'b00, 1, 0, 0);
    chk("pixels", 8, 10'(seen_px));
    print_verdict();
  end
endmodule
`default_nettype wire
